// [rtl/spm_master.sv]
/*
  Four-select serial master: register port, clock divider, character
  sequencer and shift engine. Assumes one 50 MHz clock, a synchronous
  active-high reset, and a CPU that moves every character itself.
*/
// Strobed register access was left to the implementer.
`include "spm_params.svh"
`default_nettype none

module spm_master
  import spm_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic reset,
  // Register port
  input wire logic [15:0] regAddr,
  input wire logic [15:0] regWriteData,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [15:0] regReadData,
  // Serial link
  output logic serialClock,
  output logic [3:0] slaveSelectN,
  output logic serialOut,
  input wire logic serialIn,
  // Event output
  output logic charIrq
);

  // Software-visible registers
  logic [15:0] divider_q;   // Half-period minus one, in system clocks
  logic [15:0] clkCtrl_q;   // Divider enable
  logic [15:0] cfgLow_q;    // Per-select polarity, phase, select level
  logic [15:0] cfgHigh_q;   // Per-select delay, loopback
  logic [15:0] cmdLow_q;    // Frame length minus one, interrupt enable
  logic [15:0] cmdHigh_q;   // Last command written
  logic [31:0] txData_q;    // Character to send
  logic [31:0] rxData_q;    // Last character received

  // Sequencer state
  spm_state_type state_q;
  logic [15:0] divCnt_q;    // Divider count within a half period
  logic [5:0] delayCnt_q;   // Half periods of select-to-data delay
  logic [4:0] bitCnt_q;     // Bits completed in this character
  logic [4:0] lenM1_q;      // Character length minus one
  logic [1:0] sel_q;        // Select in use for the current frame
  logic [11:0] charCnt_q;   // Characters done in this frame
  logic leading_q;          // Next edge is the leading edge
  logic csActive_q;         // A frame holds its select active
  logic [31:0] txShift_q;   // Left-aligned outgoing character
  logic [31:0] rxShift_q;   // Incoming bits, newest at bit 0
  logic charDone_q;         // Sticky character-complete flag
  logic frameDone_q;        // Sticky frame-complete flag

  // Input synchroniser; the first stage feeds only the second
  logic inMeta_q;
  logic inSync_q;

  // Combinational helpers
  logic tick;               // One half period of the serial clock
  logic startCmd;           // Software starts one character
  logic charEnd;            // Last trailing edge of a character
  logic frameEnd;           // That character closes the frame
  logic readStatLow;        // Status read clears sticky flags
  logic rxBit;              // Selected serial input
  logic cpol;               // Idle clock level of the select in use after this edge
  logic cpha;               // Phase of current select
  logic csNext; // Frame select state after this edge
  logic [1:0] selNext; // Select in use after this edge

  // One config bit for a given select
  function automatic logic cfgBit(input logic [15:0] cfg,
                                  input logic [1:0] sel,
                                  input logic [1:0] idx);
    cfgBit = cfg[{sel, idx}];
  endfunction

  // Place a character of lm1+1 bits at the top of the shifter
  function automatic logic [31:0] leftAlign(input logic [31:0] d,
                                            input logic [4:0] lm1);
    leftAlign = d << (5'h1F - lm1);
  endfunction

  // A new frame takes its select from the start command itself
  assign selNext = (startCmd && !csActive_q) ? regWriteData[`SPM_SEL_LSB +: 2] : sel_q;
  assign csNext = (startCmd && !csActive_q) || (csActive_q && !frameEnd);
  assign cpol = cfgBit(cfgLow_q, selNext, `SPM_CFG_POL_IDX);
  assign cpha = cfgBit(cfgLow_q, sel_q, `SPM_CFG_PHASE_IDX);
  // Loopback takes the driven output instead of the pin
  assign rxBit = cfgHigh_q[`SPM_LOOPBACK_BIT] ? serialOut : inSync_q;
  // Ticks only while a character is moving and the divider runs
  assign tick = (state_q != SPM_IDLE) && clkCtrl_q[`SPM_CLK_ENABLE_BIT]
                && (divCnt_q == divider_q);
  // Commands while busy are ignored, so a character is never cut short
  assign startCmd = regWrite && (regAddr == `SPM_ADDR_CMD_HIGH)
                    && regWriteData[`SPM_START_BIT] && (state_q == SPM_IDLE);
  assign charEnd = (state_q == SPM_SHIFT) && tick && !leading_q
                   && (bitCnt_q == lenM1_q);
  assign frameEnd = charEnd && (charCnt_q == cmdLow_q[11:0]);
  assign readStatLow = regRead && (regAddr == `SPM_ADDR_STAT_LOW);

  // Two-stage synchroniser for the serial input pin
  always_ff @(posedge clock) begin
    if (reset) begin
      inMeta_q <= 1'b0;
      inSync_q <= 1'b0;
    end else begin
      inMeta_q <= serialIn;
      inSync_q <= inMeta_q;
    end
  end

  // Register writes; the data registers accept writes even while busy
  always_ff @(posedge clock) begin
    if (reset) begin
      divider_q <= `SPM_RESET_DIVIDER;
      clkCtrl_q <= `SPM_RESET_WORD;
      cfgLow_q <= `SPM_RESET_WORD;
      cfgHigh_q <= `SPM_RESET_WORD;
      cmdLow_q <= `SPM_RESET_WORD;
      cmdHigh_q <= `SPM_RESET_WORD;
      txData_q <= 32'h0000_0000;
    end else if (regWrite) begin
      if (regAddr == `SPM_ADDR_DIVIDER) begin
        divider_q <= regWriteData;
      end else if (regAddr == `SPM_ADDR_CLKCTRL) begin
        clkCtrl_q <= regWriteData;
      end else if (regAddr == `SPM_ADDR_CFG_LOW) begin
        cfgLow_q <= regWriteData;
      end else if (regAddr == `SPM_ADDR_CFG_HIGH) begin
        cfgHigh_q <= regWriteData;
      end else if (regAddr == `SPM_ADDR_CMD_LOW) begin
        cmdLow_q <= regWriteData;
      end else if (regAddr == `SPM_ADDR_CMD_HIGH) begin
        cmdHigh_q <= regWriteData;
      end else if (regAddr == `SPM_ADDR_DATA_LOW) begin
        txData_q[15:0] <= regWriteData;
      end else if (regAddr == `SPM_ADDR_DATA_HIGH) begin
        txData_q[31:16] <= regWriteData;
      end
    end
  end

  // Read data stands in the cycle after the strobe; unmapped reads zero
  always_ff @(posedge clock) begin
    if (reset) begin
      regReadData <= 16'h0000;
    end else if (regRead) begin
      if (regAddr == `SPM_ADDR_DIVIDER) begin
        regReadData <= divider_q;
      end else if (regAddr == `SPM_ADDR_CLKCTRL) begin
        regReadData <= clkCtrl_q;
      end else if (regAddr == `SPM_ADDR_CFG_LOW) begin
        regReadData <= cfgLow_q;
      end else if (regAddr == `SPM_ADDR_CFG_HIGH) begin
        regReadData <= cfgHigh_q;
      end else if (regAddr == `SPM_ADDR_CMD_LOW) begin
        regReadData <= cmdLow_q;
      end else if (regAddr == `SPM_ADDR_CMD_HIGH) begin
        regReadData <= cmdHigh_q;
      end else if (regAddr == `SPM_ADDR_STAT_LOW) begin
        regReadData <= {13'h0000, frameDone_q, charDone_q,
                        state_q != SPM_IDLE};
      end else if (regAddr == `SPM_ADDR_STAT_HIGH) begin
        regReadData <= {4'h0, charCnt_q};
      end else if (regAddr == `SPM_ADDR_DATA_LOW) begin
        regReadData <= rxData_q[15:0];
      end else if (regAddr == `SPM_ADDR_DATA_HIGH) begin
        regReadData <= rxData_q[31:16];
      end else begin
        regReadData <= 16'h0000;
      end
    end else begin
      // Data only stand for one cycle
      regReadData <= 16'h0000;
    end
  end

  // Sticky completion flags; a new completion wins over the read clear
  always_ff @(posedge clock) begin
    if (reset) begin
      charDone_q <= 1'b0;
      frameDone_q <= 1'b0;
    end else begin
      if (charEnd) begin
        charDone_q <= 1'b1;
      end else if (readStatLow) begin
        charDone_q <= 1'b0;
      end
      if (frameEnd) begin
        frameDone_q <= 1'b1;
      end else if (readStatLow) begin
        frameDone_q <= 1'b0;
      end
    end
  end

  // Interrupt pulse per character, only when software enabled it
  always_ff @(posedge clock) begin
    if (reset) begin
      charIrq <= 1'b0;
    end else begin
      charIrq <= charEnd && cmdLow_q[`SPM_IRQ_ENABLE_BIT];
    end
  end

  // Divider count; restarts whenever idle so the first edge is exact
  always_ff @(posedge clock) begin
    if (reset) begin
      divCnt_q <= 16'h0000;
    end else if (state_q == SPM_IDLE || tick) begin
      divCnt_q <= 16'h0000;
    end else if (clkCtrl_q[`SPM_CLK_ENABLE_BIT]) begin
      divCnt_q <= divCnt_q + 16'h0001;
    end
  end

  // Sequencer: idle, select-to-data delay, shifting
  always_ff @(posedge clock) begin
    if (reset) begin
      state_q <= SPM_IDLE;
      delayCnt_q <= 6'h00;
      bitCnt_q <= 5'h00;
      lenM1_q <= 5'h00;
      leading_q <= 1'b1;
    end else begin
      case (state_q)
        SPM_IDLE: begin
          if (startCmd) begin
            lenM1_q <= regWriteData[`SPM_LEN_LSB +: 5];
            bitCnt_q <= 5'h00;
            leading_q <= 1'b1;
            // Delay applies only when the select first goes active
            if (!csActive_q && cfgHigh_q[{regWriteData[3:2], 1'b0} +: 2] != 2'h0) begin
              delayCnt_q <= {3'h0, cfgHigh_q[{regWriteData[3:2], 1'b0} +: 2], 1'b0};
              state_q <= SPM_DELAY;
            end else begin
              state_q <= SPM_SHIFT;
            end
          end
        end
        SPM_DELAY: begin
          // Two half periods per programmed clock period
          if (tick) begin
            if (delayCnt_q == 6'h01) begin
              state_q <= SPM_SHIFT;
            end
            delayCnt_q <= delayCnt_q - 6'h01;
          end
        end
        SPM_SHIFT: begin
          if (tick) begin
            leading_q <= !leading_q;
            if (!leading_q) begin
              bitCnt_q <= bitCnt_q + 5'h01;
              if (charEnd) begin
                state_q <= SPM_IDLE;
              end
            end
          end
        end
        default: begin
          state_q <= SPM_IDLE;
        end
      endcase
    end
  end

  // Frame bookkeeping: select choice and character count
  always_ff @(posedge clock) begin
    if (reset) begin
      csActive_q <= 1'b0;
      sel_q <= 2'h0;
      charCnt_q <= 12'h000;
    end else if (startCmd && !csActive_q) begin
      // Select is latched once per frame and held until it ends
      csActive_q <= 1'b1;
      sel_q <= regWriteData[`SPM_SEL_LSB +: 2];
      charCnt_q <= 12'h000;
    end else if (frameEnd) begin
      csActive_q <= 1'b0;
      charCnt_q <= 12'h000;
    end else if (charEnd) begin
      charCnt_q <= charCnt_q + 12'h001;
    end
  end

  // Shift engine; phase picks which edge launches and which samples
  always_ff @(posedge clock) begin
    if (reset) begin
      txShift_q <= 32'h0000_0000;
      rxShift_q <= 32'h0000_0000;
      rxData_q <= 32'h0000_0000;
      serialOut <= 1'b0;
    end else if (startCmd) begin
      txShift_q <= leftAlign(txData_q, regWriteData[`SPM_LEN_LSB +: 5]);
      // Stale bits would otherwise show above a short character
      rxShift_q <= 32'h0000_0000;
      // Phase 0 needs its first bit, bit length-1, before the leading edge
      serialOut <= txData_q[regWriteData[`SPM_LEN_LSB +: 5]];
    end else if (state_q == SPM_SHIFT && tick) begin
      if (leading_q) begin
        if (cpha) begin
          serialOut <= txShift_q[31];
          txShift_q <= {txShift_q[30:0], 1'b0};
        end else begin
          rxShift_q <= {rxShift_q[30:0], rxBit};
        end
      end else begin
        if (cpha) begin
          rxShift_q <= {rxShift_q[30:0], rxBit};
          if (charEnd) begin
            rxData_q <= {rxShift_q[30:0], rxBit};
          end
        end else begin
          serialOut <= txShift_q[30];
          txShift_q <= {txShift_q[30:0], 1'b0};
          if (charEnd) begin
            rxData_q <= rxShift_q;
          end
        end
      end
    end
  end

  // Serial clock: idle level when not shifting, toggled per half period
  always_ff @(posedge clock) begin
    if (reset) begin
      serialClock <= 1'b0;
    end else if (state_q != SPM_SHIFT) begin
      // Follows the select about to be used, so unrelated writes never move it
      serialClock <= cpol;
    end else if (tick) begin
      serialClock <= !serialClock;
    end
  end

  // Chip selects: only the chosen one asserts, at its own level
  // Built from next-frame state so the select leads the first clock edge
  always_ff @(posedge clock) begin
    if (reset) begin
      slaveSelectN <= 4'hF;
    end else begin
      for (int i = 0; i < 4; i++) begin
        // Low-active unless the select is set for active high
        slaveSelectN[i] <= (csNext && selNext == 2'(i))
                           == cfgLow_q[4 * i + 2];
      end
    end
  end

endmodule
`default_nettype wire

// [rtl/spm_params.svh]
/*
  Constants for the four-select serial master: word addresses, field
  positions and reset values. Assumes inclusion by bare name only.
*/
`ifndef SPM_PARAMS_SVH
`define SPM_PARAMS_SVH
// Word addresses of the ten registers
`define SPM_ADDR_DIVIDER   16'h3000
`define SPM_ADDR_CLKCTRL   16'h3001
`define SPM_ADDR_CFG_LOW   16'h3002
`define SPM_ADDR_CFG_HIGH  16'h3003
`define SPM_ADDR_CMD_LOW   16'h3004
`define SPM_ADDR_CMD_HIGH  16'h3005
`define SPM_ADDR_STAT_LOW  16'h3006
`define SPM_ADDR_STAT_HIGH 16'h3007
`define SPM_ADDR_DATA_LOW  16'h3008
`define SPM_ADDR_DATA_HIGH 16'h3009
// Reset values
`define SPM_RESET_WORD     16'h0000
`define SPM_RESET_DIVIDER  16'h0001
// Field positions
`define SPM_CLK_ENABLE_BIT 15
`define SPM_LOOPBACK_BIT   15
`define SPM_IRQ_ENABLE_BIT 14
`define SPM_START_BIT      0
`define SPM_SEL_LSB        2
`define SPM_LEN_LSB        4
`define SPM_BUSY_BIT       0
`define SPM_CHARDONE_BIT   1
`define SPM_FRAMEDONE_BIT  2
// Per-select config layout in config_low, four bits per select
`define SPM_CFG_POL_IDX    2'h0
`define SPM_CFG_PHASE_IDX  2'h1
`define SPM_CFG_CSHI_IDX   2'h2
`endif

// [rtl/spm_pkg.sv]
/*
  Types for the four-select serial master.
  Assumes nothing beyond a SystemVerilog compiler.
*/
`default_nettype none
package spm_pkg;
  // Sequencer states
  typedef enum logic [1:0] {
    SPM_IDLE,
    SPM_DELAY,
    SPM_SHIFT
  } spm_state_type;
endpackage
`default_nettype wire

// [verif/spm_master_chk.sv]
/*
  Port checker for spm_master, bound to every instance of it.
  Assumes polarity, divider and frame settings change only between frames.
*/
`include "spm_params.svh"
`default_nettype none
module spm_master_chk (
  // Clock and reset
  input wire logic clock,
  input wire logic reset,
  // Register port
  input wire logic [15:0] regAddr,
  input wire logic [15:0] regWriteData,
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [15:0] regReadData,
  // Serial link and event
  input wire logic serialClock,
  input wire logic [3:0] slaveSelectN,
  input wire logic serialOut,
  input wire logic serialIn,
  input wire logic charIrq
);
  default clocking @(posedge clock); endclocking
  default disable iff (reset);
  logic [15:0] cfgLow_q; // Shadow of select polarity bits
  logic [15:0] div_q; // Shadow of the divider
  logic irqEn_q; // Shadow of the character interrupt enable
  logic lastClk_q; // Serial clock one cycle ago
  logic sawEdge_q; // An edge already seen in this character
  logic [16:0] cnt_q; // Cycles since the last serial clock change
  logic [3:0] act; // Selects at their active level
  logic startWr; // Software starts a character
  assign startWr = regWrite && regAddr == `SPM_ADDR_CMD_HIGH && regWriteData[0];
  // Active level depends on each select's own polarity bit
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      act[i] = slaveSelectN[i] == cfgLow_q[4*i+2];
    end
  end
  // Shadow registers follow software writes
  always_ff @(posedge clock) begin
    if (reset) begin
      cfgLow_q <= 16'h0000;
      div_q <= 16'h0001;
      irqEn_q <= 1'b0;
    end else if (regWrite) begin
      if (regAddr == `SPM_ADDR_CFG_LOW) cfgLow_q <= regWriteData;
      if (regAddr == `SPM_ADDR_DIVIDER) div_q <= regWriteData;
      if (regAddr == `SPM_ADDR_CMD_LOW) irqEn_q <= regWriteData[14];
    end
  end
  // Half-period timer; the first edge of a character is skipped, as the idle gap and any delay before it stretch it
  always_ff @(posedge clock) begin
    lastClk_q <= serialClock;
    cnt_q <= (serialClock != lastClk_q) ? 17'h00001 : cnt_q + 17'h00001;
    if (reset || !(|act) || startWr) sawEdge_q <= 1'b0;
    else if (serialClock != lastClk_q) sawEdge_q <= 1'b1;
  end
  a_read_zero_idle: assert property (!$past(regRead) |-> regReadData == 16'h0000)
    else $error("read data not zero outside a read answer");
  a_reset_idle_level: assert property ($past(reset) |-> slaveSelectN == 4'hF && !serialClock)
    else $error("link not idle after reset");
  a_irq_single_pulse: assert property (charIrq |=> !charIrq)
    else $error("character interrupt longer than one cycle");
  a_irq_when_enabled: assert property (charIrq |-> irqEn_q)
    else $error("character interrupt while disabled");
  a_one_select_active: assert property ($onehot0(act))
    else $error("more than one select active");
  a_idle_clock_steady: assert property ((!(|act) && $stable(cfgLow_q)) [*3] |-> $stable(serialClock))
    else $error("serial clock moves with no select active");
  a_start_drives_select: assert property (startWr && !(|act) |-> ##[1:2] |act)
    else $error("start did not assert a select");
  a_half_period_rate: assert property ($changed(serialClock) && sawEdge_q |->
      cnt_q == {1'b0, div_q} + 17'h00001)
    else $error("serial clock half period differs from divider");
  c_irq_seen: cover property (charIrq);
  c_frame_start: cover property (startWr && !(|act));
  c_inner_edge: cover property ($changed(serialClock) && sawEdge_q);
endmodule
bind spm_master spm_master_chk u_chk (.clock(clock), .reset(reset), .regAddr(regAddr),
  .regWriteData(regWriteData), .regWrite(regWrite), .regRead(regRead),
  .regReadData(regReadData), .serialClock(serialClock), .slaveSelectN(slaveSelectN),
  .serialOut(serialOut), .serialIn(serialIn), .charIrq(charIrq));
`default_nettype wire

// [verif/spm_slave_model.sv]
/*
  Behavioural slave with rising-edge sample and falling-edge launch.
  Assumes an active-low select and a master that sends the MSB first.
*/
`default_nettype none
module spm_slave_model (
  // Link from the master
  input wire logic serialClock,
  input wire logic selectN,
  input wire logic masterOut,
  output logic slaveOut,
  // Bench side
  input wire logic [31:0] replyWord,
  output logic [31:0] rxWord
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [31:0] sh = 32'h0000_0000; // Reply being shifted out
  logic lastOut = 1'b0; // Last bit driven before release
  // Released line shows the inverse of its last bit, so a stale value never passes
  assign slaveOut = selectN ? ~lastOut : sh[31];
  // Load the reply and clear the receiver when selected
  always @(negedge selectN) begin
    sh = replyWord;
    rxWord = 32'h0000_0000;
  end
  // Sample master data on the rising edge
  always @(posedge serialClock) if (!selectN) rxWord <= {rxWord[30:0], masterOut};
  // Launch the next reply bit on the falling edge
  always @(negedge serialClock) if (!selectN) sh <= sh << 1;
  always @(posedge selectN) lastOut = sh[31];
endmodule
`default_nettype wire

// [verif/tb_spm_master.sv]
/*
  Self-checking bench for spm_master with a slave model on select 0.
  Assumes the register map and timing of the designer's hand-over.
*/
`include "spm_params.svh"
`default_nettype none
module tb_spm_master;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock = 1'b0, reset = 1'b1, regWrite = 1'b0, regRead = 1'b0;
  logic [15:0] regAddr = 16'h0000, regWriteData = 16'h0000, regReadData, rdv, st;
  logic serialClock, serialOut, serialIn, charIrq;
  logic [3:0] slaveSelectN;
  logic [31:0] replyWord = 32'h3C00_0000, rxWord;
  int numErrors = 0, testsRun = 0, cycles = 0, sclkRises = 0, irqCount = 0;
  always #10 clock = ~clock; // 50 MHz
  spm_master u_dut (.clock(clock), .reset(reset), .regAddr(regAddr),
    .regWriteData(regWriteData), .regWrite(regWrite), .regRead(regRead),
    .regReadData(regReadData), .serialClock(serialClock), .slaveSelectN(slaveSelectN),
    .serialOut(serialOut), .serialIn(serialIn), .charIrq(charIrq));
  spm_slave_model u_slave (.serialClock(serialClock), .selectN(slaveSelectN[0]),
    .masterOut(serialOut), .slaveOut(serialIn), .replyWord(replyWord), .rxWord(rxWord));
  always @(posedge serialClock) sclkRises++;
  // Interrupt count and hang guard
  always @(posedge clock) begin
    cycles++;
    if (charIrq === 1'b1) irqCount++;
    if (cycles == 20000) begin
      numErrors++;
      report_and_stop();
    end
  end
  task automatic report_and_stop();
    $display("errors %0d checks %0d", numErrors, testsRun);
    if (numErrors == 0 && testsRun > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    testsRun++;
    if (seen !== exp) begin
      numErrors++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(posedge clock);
    regWrite <= 1'b1;
    regAddr <= a;
    regWriteData <= d;
    @(posedge clock);
    regWrite <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [15:0] a, output logic [15:0] d);
    @(posedge clock);
    regRead <= 1'b1;
    regAddr <= a;
    @(posedge clock);
    regRead <= 1'b0;
    #1 d = regReadData;
  endtask
  task automatic start(input logic [1:0] s, input logic [4:0] m);
    wr(`SPM_ADDR_CMD_HIGH, {7'h00, m, s, 2'b01});
  endtask
  // Bounded busy poll; margin lets the late interrupt pulse land
  task automatic wait_idle();
    st = 16'h0001;
    for (int i = 0; i < 300 && st[0] !== 1'b0; i++) rd(`SPM_ADDR_STAT_LOW, st);
    check(st[0], 1'b0);
    repeat (4) @(posedge clock);
    #1;
  endtask
  task automatic t_reset_map();
    #1 check(slaveSelectN, 4'hF);
    check(serialClock, 1'b0);
    for (logic [15:0] a = 16'h3000; a <= 16'h300A; a++) begin
      rd(a, rdv);
      check(rdv, a == `SPM_ADDR_DIVIDER ? 16'h0001 : 16'h0000);
    end
    wr(`SPM_ADDR_STAT_LOW, 16'hFFFF);
    rd(`SPM_ADDR_STAT_LOW, rdv);
    check(rdv, 16'h0000);
  endtask
  task automatic t_slave_duplex();
    wr(`SPM_ADDR_CLKCTRL, 16'h8000);
    wr(`SPM_ADDR_DIVIDER, 16'h0003);
    wr(`SPM_ADDR_DATA_LOW, 16'h00A5);
    sclkRises = 0;
    start(2'h0, 5'h07);
    wait_idle();
    check(st[1], 1'b1);
    check(sclkRises, 8);
    check(rxWord[7:0], 8'hA5);
    rd(`SPM_ADDR_DATA_LOW, rdv);
    check(rdv, 16'h003C);
    rd(`SPM_ADDR_STAT_LOW, rdv);
    check(rdv[1], 1'b0);
  endtask
  task automatic t_loop_lengths();
    wr(`SPM_ADDR_DIVIDER, 16'h0000);
    wr(`SPM_ADDR_CFG_HIGH, 16'h8000);
    wr(`SPM_ADDR_DATA_LOW, 16'h9ABC);
    wr(`SPM_ADDR_DATA_HIGH, 16'h1234);
    start(2'h0, 5'h1F);
    wait_idle();
    rd(`SPM_ADDR_DATA_LOW, rdv);
    check(rdv, 16'h9ABC);
    rd(`SPM_ADDR_DATA_HIGH, rdv);
    check(rdv, 16'h1234);
    wr(`SPM_ADDR_DATA_LOW, 16'h0001);
    start(2'h0, 5'h00);
    wait_idle();
    rd(`SPM_ADDR_DATA_LOW, rdv);
    check(rdv[0], 1'b1);
    // Phase 1 on select 0: launch on the leading edge, sample on the trailing
    wr(`SPM_ADDR_CFG_LOW, 16'h0002);
    wr(`SPM_ADDR_DATA_LOW, 16'hC35A);
    start(2'h0, 5'h0F);
    wait_idle();
    rd(`SPM_ADDR_DATA_LOW, rdv);
    check(rdv, 16'hC35A);
    wr(`SPM_ADDR_CFG_LOW, 16'h0000);
  endtask
  task automatic t_selects();
    wr(`SPM_ADDR_DIVIDER, 16'h0003);
    for (int s = 0; s < 4; s++) begin
      start(2'(s), 5'h00);
      repeat (2) @(posedge clock);
      #1 check(slaveSelectN, 4'(~(4'h1 << s)));
      wait_idle();
    end
  endtask
  // Count cycles from select active to the first clock edge
  task automatic t_delays();
    int n, got;
    logic seen;
    wr(`SPM_ADDR_DIVIDER, 16'h0000);
    for (int d = 0; d < 4; d++) begin
      wr(`SPM_ADDR_CFG_HIGH, 16'h8000 | 16'(d));
      start(2'h0, 5'h00);
      n = 0;
      got = 0;
      seen = 1'b0;
      // Sampling starts in the cycle right after the start write is taken
      for (int i = 0; i < 40; i++) begin
        #1 if (seen && got == 0 && serialClock === 1'b1) got = n;
        if (slaveSelectN[0] === 1'b0) begin
          seen = 1'b1;
          n++;
        end
        @(posedge clock);
      end
      check(got, 1 + 2 * d);
      wait_idle();
    end
  endtask
  task automatic t_polarity();
    wr(`SPM_ADDR_CFG_LOW, 16'h0005);
    repeat (3) @(posedge clock);
    #1 check(serialClock, 1'b1);
    check(slaveSelectN, 4'hE);
    start(2'h0, 5'h00);
    repeat (2) @(posedge clock);
    #1 check(slaveSelectN[0], 1'b1);
    wait_idle();
    wr(`SPM_ADDR_CFG_LOW, 16'h0000);
  endtask
  task automatic t_irq_frame();
    wr(`SPM_ADDR_CMD_LOW, 16'h4001);
    irqCount = 0;
    start(2'h0, 5'h00);
    wait_idle();
    check(slaveSelectN[0], 1'b0);
    check(irqCount, 1);
    start(2'h0, 5'h00);
    wait_idle();
    check(slaveSelectN[0], 1'b1);
    check(st[2], 1'b1);
    wr(`SPM_ADDR_CMD_LOW, 16'h0000);
    start(2'h0, 5'h00);
    wait_idle();
    check(irqCount, 2);
  endtask
  initial begin
    repeat (4) @(posedge clock);
    reset <= 1'b0;
    t_reset_map();
    t_slave_duplex();
    t_loop_lengths();
    t_selects();
    t_delays();
    t_polarity();
    t_irq_frame();
    report_and_stop();
  end
endmodule
`default_nettype wire
